// file: verilog/syscfg_top.sv
// system configuration register and the control it steers
// assumes core register port on CLK; strap pins come from outside the domain
// Operation
// [R1] writing soft reset acts like reset pin
// [R2] boot override: bank selects off, boot select on
// [R3] no boot: vector table internal or external
// [R4] any boot mode: vector table always internal
// [R5] instruction width bit forces 48-bit direct access
// [R6] host pack mode selects bus and word
// [R7] no packing: low 16 data bits zero
// [R8] iop registers 32-bit; link buffers follow pack
// [R9] software matches pack mode to dma pack
// [R10] 16/32 mode, wide block: upper 32 bits
// [R11] pack change: write, read, write, wait
// [R12] pack order high first, not for 32/48
// [R13] flush clears pack status; reads zero
// [R14] host idles during flush latency
// [R15] bits 8, 9 set block data width
// [R16] buffer stall unless stall disable set
// [R17] bank size field is log2 minus 13
// [R18] bus priority: even, core, or io
// [R19] conflicting pm and dm: dm first
// [R20] priority side waits out the other; the code grants the priority side at once and the other side waits
// [R21] even priority alternates every other cycle
// [R22] dma channels fixed or rotating priority
// [R23] reset value sets 16/32 packing
`timescale 1ns/1ps
`include "syscfg_cfg.svh"
module syscfg_top
	import syscfg_pkg::*;
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic [31:0] REG_ADDR,
	input wire logic REG_WE,
	input wire logic REG_RE,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic SOFT_RESET,
	input wire logic EPROM_BOOT_STRAP,
	input wire logic LINK_BOOT_STRAP,
	input wire logic BOOT_MEM_STRAP,
	output logic [31:0] VECTOR_BASE,
	input wire logic [3:0] BANK_REQ,
	input wire logic BOOT_REQ,
	output logic [3:0] BANK_SEL_N,
	output logic BOOT_SEL_N,
	input wire logic DIRECT_BLOCK,
	output syscfg_width_t DIRECT_WIDTH,
	input syscfg_target_t HOST_TARGET,
	input wire logic HOST_BLOCK,
	output syscfg_width_t HOST_WIDTH,
	output logic HOST_UPPER32,
	output logic [1:0] HOST_PACK_MODE,
	output logic HOST_PACK_HIGH_FIRST,
	output logic PACK_FLUSH,
	input wire logic [47:0] HOST_DATA_IN,
	output logic [47:0] HOST_DATA_OUT,
	output logic BLOCK0_WIDE,
	output logic BLOCK1_WIDE,
	output logic REDY_ACTIVE_DRIVE,
	input wire logic BUF_EMPTY_RD,
	input wire logic BUF_FULL_WR,
	output logic BUF_STALL,
	output logic [4:0] BANK_SIZE_LOG2,
	input syscfg_bus_req_t BUS_REQ,
	output syscfg_bus_gnt_t BUS_GNT,
	input wire logic [3:0] DMA_REQ,
	output logic [3:0] DMA_GNT
);
	localparam syscfg_state_t SC_RST_STATE = '{
		cfg: `SC_RESET, // [R23]
		flush: SC_FL_IDLE,
		soft_reset_bit: 1'b0,
		strap_s1: 3'h0,
		strap_s2: 3'h0,
		last_io: 1'b0,
		bank_n: `SC_BANK_OFF,
		boot_n: 1'b1,
		data: 48'h0,
		rdata: 32'h0
	};

	syscfg_state_t s_r;
	syscfg_state_t n;
	logic [1:0] host_pack_mode;
	logic [1:0] external_bus_priority;
	logic booting;
	logic core_win;

	// the register sits at one word of internal memory
	function automatic logic hit(input logic [31:0] a);
		return a == `SC_ADDR;
	endfunction

	// width of a block access: instruction transfer overrides the block bit
	function automatic syscfg_width_t blk_width(input logic instruction_transfer_width_bit, input logic wide);
		if (instruction_transfer_width_bit) return SC_W48; // [R5]
		return wide ? SC_W40 : SC_W32; // [R5]
	endfunction

	// word width given by the host pack mode alone
	function automatic syscfg_width_t pack_width(input logic [1:0] mode);
		case (mode)
			`SC_HPM_16_48: return SC_W48; // [R6]
			`SC_HPM_32_48: return SC_W48; // [R6]
			default: return SC_W32; // [R6]
		endcase
	endfunction

	// block data width bit for block 0 or 1
	function automatic logic blk_bit(input logic [31:0] c, input logic blk);
		return blk ? c[`SC_B_BLK1] : c[`SC_B_BLK0]; // [R15]
	endfunction

	assign host_pack_mode = s_r.cfg[`SC_HPM_HI:`SC_HPM_LO];
	assign external_bus_priority = s_r.cfg[`SC_EXTERNAL_BUS_PRIORITY_HI:`SC_EXTERNAL_BUS_PRIORITY_LO];
	// any strap set means a boot mode; synced copies only
	assign booting = |s_r.strap_s2;

	// plain decodes of stored configuration
	assign VECTOR_BASE = (booting || s_r.cfg[`SC_B_VECTOR_TABLE_INTERNAL_BIT]) ? `SC_IVT_INT : `SC_IVT_EXT; // [R3] [R4]
	assign DIRECT_WIDTH = blk_width(s_r.cfg[`SC_B_IWT], blk_bit(s_r.cfg, DIRECT_BLOCK));
	assign HOST_PACK_MODE = host_pack_mode; // [R6]
	assign BLOCK0_WIDE = s_r.cfg[`SC_B_BLK0]; // [R15]
	assign BLOCK1_WIDE = s_r.cfg[`SC_B_BLK1]; // [R15]
	assign REDY_ACTIVE_DRIVE = s_r.cfg[`SC_B_REDY];
	assign BANK_SIZE_LOG2 = 5'(s_r.cfg[`SC_BANK_SIZE_FIELD_HI:`SC_BANK_SIZE_FIELD_LO]) + `SC_BANK_SIZE_FIELD_BIAS; // [R17]
	// order only matters when 16-bit words are packed
	assign HOST_PACK_HIGH_FIRST = s_r.cfg[`SC_B_HOST_PACK_HIGH_FIRST] &&
		(host_pack_mode == `SC_HPM_16_32 || host_pack_mode == `SC_HPM_16_48); // [R12]
	// stall is combinational so the requester holds in the same cycle
	assign BUF_STALL = !s_r.cfg[`SC_B_BHD] && (BUF_EMPTY_RD || BUF_FULL_WR); // [R16]
	assign PACK_FLUSH = s_r.flush == SC_FL_FIRE; // [R13]
	assign SOFT_RESET = s_r.soft_reset_bit; // [R1]
	assign REG_RDATA = s_r.rdata;
	assign BANK_SEL_N = s_r.bank_n;
	assign BOOT_SEL_N = s_r.boot_n;
	assign HOST_DATA_OUT = s_r.data;

	// host word width per target; iop registers ignore packing
	always_comb begin
		HOST_WIDTH = SC_W32;
		HOST_UPPER32 = 1'b0;
		case (HOST_TARGET)
			SC_TGT_IOP: HOST_WIDTH = SC_W32; // [R8]
			SC_TGT_LINK: HOST_WIDTH = pack_width(host_pack_mode); // [R8]
			SC_TGT_PORT: HOST_WIDTH = pack_width(host_pack_mode);
			SC_TGT_MEM: begin
				if (host_pack_mode == `SC_HPM_NONE) begin
					HOST_WIDTH = blk_width(s_r.cfg[`SC_B_IWT], blk_bit(s_r.cfg, HOST_BLOCK));
				end else begin
					HOST_WIDTH = pack_width(host_pack_mode); // [R6]
				end
				// 32-bit words into a 40-bit block land in the top 32 bits
				HOST_UPPER32 = host_pack_mode == `SC_HPM_16_32 && blk_bit(s_r.cfg, HOST_BLOCK); // [R10]
			end
			default: HOST_WIDTH = SC_W32;
		endcase
	end

	// external bus slot: one winner per cycle, dm ahead of pm
	always_comb begin
		logic core;
		core = BUS_REQ.pm_req || BUS_REQ.dm_req;
		case (external_bus_priority)
			`SC_EXTERNAL_BUS_PRIORITY_CORE: core_win = core; // [R18] [R20]
			`SC_EXTERNAL_BUS_PRIORITY_IOP: core_win = core && !BUS_REQ.io_req; // [R18] [R20]
			default: core_win = core && (!BUS_REQ.io_req || s_r.last_io); // [R18] [R21]
		endcase
		BUS_GNT.io = BUS_REQ.io_req && !core_win;
		BUS_GNT.dm = core_win && BUS_REQ.dm_req; // [R19]
		// pm takes the extra cycle after dm; it keeps requesting meanwhile
		BUS_GNT.pm = core_win && BUS_REQ.pm_req && !BUS_REQ.dm_req; // [R19]
	end

	// next state of the whole block
	always_comb begin
		n = s_r;
		// straps pass two flops before any decode
		n.strap_s1 = {EPROM_BOOT_STRAP, LINK_BOOT_STRAP, BOOT_MEM_STRAP};
		n.strap_s2 = s_r.strap_s1;
		n.soft_reset_bit = 1'b0;
		// flush latency walk
		case (s_r.flush)
			SC_FL_WAIT: n.flush = SC_FL_FIRE; // [R13]
			SC_FL_FIRE: n.flush = SC_FL_IDLE;
			default: n.flush = SC_FL_IDLE;
		endcase
		// register write; reset and flush bits act but are not stored
		if (REG_WE && hit(REG_ADDR)) begin
			n.cfg = REG_WDATA & `SC_WMASK; // [R13]
			n.soft_reset_bit = REG_WDATA[`SC_B_SOFT_RESET_BIT]; // [R1]
			if (REG_WDATA[`SC_B_FLUSH]) n.flush = SC_FL_WAIT; // [R13]
		end
		// read returns the value before a same-cycle write
		n.rdata = (REG_RE && hit(REG_ADDR)) ? s_r.cfg : 32'h0;
		// boot override reroutes bank selects to the boot memory select
		if (s_r.cfg[`SC_B_BSO]) begin
			n.bank_n = `SC_BANK_OFF; // [R2]
			n.boot_n = !(BOOT_REQ || (|BANK_REQ)); // [R2]
		end else begin
			n.bank_n = ~BANK_REQ;
			n.boot_n = !BOOT_REQ;
		end
		// unpacked host bus is at most 32 bits wide
		if (host_pack_mode == `SC_HPM_NONE) n.data = HOST_DATA_IN & `SC_LOW16_MASK; // [R7]
		else n.data = HOST_DATA_IN;
		// remember last winner so even priority alternates
		if (BUS_GNT.io) n.last_io = 1'b1; // [R21]
		else if (core_win) n.last_io = 1'b0;
		// soft reset pulse reloads everything like the pin
		if (s_r.soft_reset_bit) n = SC_RST_STATE; // [R1]
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) s_r <= SC_RST_STATE; // [R23]
		else s_r <= n;
	end

	// dma channel 6 to 9 priority
	syscfg_dma_arb u_dma_arb (
		.clk(CLK),
		.rst(RST),
		.clr(s_r.soft_reset_bit),
		.rotate(s_r.cfg[`SC_B_DMA_CHANNEL_PRIORITY_BIT]), // [R22]
		.req(DMA_REQ),
		.gnt(DMA_GNT)
	);

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	property p_soft_reset_bit;
		REG_WE && hit(REG_ADDR) && REG_WDATA[`SC_B_SOFT_RESET_BIT] |=> SOFT_RESET ##1
			(s_r.cfg == `SC_RESET && !SOFT_RESET && PACK_FLUSH == 1'b0);
	endproperty
	a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset not applied"); // [R1]
	property p_bso;
		s_r.cfg[`SC_B_BSO] && (|BANK_REQ) |=> BANK_SEL_N == `SC_BANK_OFF && !BOOT_SEL_N;
	endproperty
	a_bso: assert property (p_bso) else $error("boot override select wrong"); // [R2]
	property p_ivt;
		!booting && !s_r.cfg[`SC_B_VECTOR_TABLE_INTERNAL_BIT] |-> VECTOR_BASE == `SC_IVT_EXT;
	endproperty
	a_ivt: assert property (p_ivt) else $error("vector table not external"); // [R3]
	property p_ivt_boot;
		booting |-> VECTOR_BASE == `SC_IVT_INT;
	endproperty
	a_ivt_boot: assert property (p_ivt_boot) else $error("boot vector not internal"); // [R4]
	property p_low16;
		host_pack_mode == `SC_HPM_NONE |=> HOST_DATA_OUT[15:0] == 16'h0000;
	endproperty
	a_low16: assert property (p_low16) else $error("low 16 bits not zero"); // [R7]
	property p_iop32;
		HOST_TARGET == SC_TGT_IOP |-> HOST_WIDTH == SC_W32;
	endproperty
	a_iop32: assert property (p_iop32) else $error("iop access not 32-bit"); // [R8]
	property p_flush;
		REG_WE && hit(REG_ADDR) && REG_WDATA[`SC_B_FLUSH] && !REG_WDATA[`SC_B_SOFT_RESET_BIT] ##1
			!REG_WE |-> !PACK_FLUSH ##1 PACK_FLUSH ##1 !PACK_FLUSH;
	endproperty
	a_flush: assert property (p_flush) else $error("flush latency wrong"); // [R13]
	property p_flush_rd0;
		!REG_RDATA[`SC_B_FLUSH] && !REG_RDATA[`SC_B_SOFT_RESET_BIT];
	endproperty
	a_flush_rd0: assert property (p_flush_rd0) else $error("flush bit read as one"); // [R13]
	property p_stall;
		BUF_EMPTY_RD && $stable(s_r.cfg) |-> BUF_STALL == !s_r.cfg[`SC_B_BHD];
	endproperty
	a_stall: assert property (p_stall) else $error("buffer stall wrong"); // [R16]
	property p_core_pri;
		external_bus_priority == `SC_EXTERNAL_BUS_PRIORITY_CORE && (BUS_REQ.pm_req || BUS_REQ.dm_req) |-> !BUS_GNT.io;
	endproperty
	a_core_pri: assert property (p_core_pri) else $error("io won under core priority"); // [R20]
	property p_dm_first;
		BUS_REQ.pm_req && BUS_REQ.dm_req && (BUS_REQ.pm_write == BUS_REQ.dm_write)
			&& core_win |-> BUS_GNT.dm && !BUS_GNT.pm;
	endproperty
	a_dm_first: assert property (p_dm_first) else $error("pm went before dm"); // [R19]
	property p_even;
		(external_bus_priority == `SC_EXTERNAL_BUS_PRIORITY_EVEN && BUS_REQ.io_req && BUS_REQ.dm_req)[*2]
			|-> BUS_GNT.io != $past(BUS_GNT.io);
	endproperty
	a_even: assert property (p_even) else $error("even priority not alternating"); // [R21]

	// further decode and arbitration checks
	property p_direct48;
		s_r.cfg[`SC_B_IWT] |-> DIRECT_WIDTH == SC_W48;
	endproperty
	a_direct48: assert property (p_direct48) else $error("direct width not 48"); // [R5]
	property p_direct_blk;
		!s_r.cfg[`SC_B_IWT] && !DIRECT_BLOCK |-> DIRECT_WIDTH == (BLOCK0_WIDE ? SC_W40 : SC_W32);
	endproperty
	a_direct_blk: assert property (p_direct_blk) else $error("direct width ignores block"); // [R5]
	property p_link_pack;
		HOST_TARGET == SC_TGT_LINK && host_pack_mode == `SC_HPM_16_32 |-> HOST_WIDTH == SC_W32;
	endproperty
	a_link_pack: assert property (p_link_pack) else $error("link width not from pack mode"); // [R8]
	property p_pack_16_48;
		HOST_TARGET == SC_TGT_MEM && host_pack_mode == `SC_HPM_16_48 |-> HOST_WIDTH == SC_W48;
	endproperty
	a_pack_16_48: assert property (p_pack_16_48) else $error("pack mode width wrong"); // [R6]
	property p_upper32;
		HOST_TARGET == SC_TGT_MEM && host_pack_mode == `SC_HPM_16_32 && !HOST_BLOCK && BLOCK0_WIDE
			|-> HOST_UPPER32;
	endproperty
	a_upper32: assert property (p_upper32) else $error("upper 32 bits not selected"); // [R10]
	property p_order_32_48;
		host_pack_mode == `SC_HPM_32_48 |-> !HOST_PACK_HIGH_FIRST;
	endproperty
	a_order_32_48: assert property (p_order_32_48) else $error("order used for 32/48"); // [R12]
	property p_wr_blk;
		REG_WE && hit(REG_ADDR) && !SOFT_RESET |=>
			BLOCK0_WIDE == $past(REG_WDATA[`SC_B_BLK0]) && BLOCK1_WIDE == $past(REG_WDATA[`SC_B_BLK1]);
	endproperty
	a_wr_blk: assert property (p_wr_blk) else $error("block width bit not stored"); // [R15]
	property p_stall_off;
		s_r.cfg[`SC_B_BHD] |-> !BUF_STALL;
	endproperty
	a_stall_off: assert property (p_stall_off) else $error("stall with stall disable"); // [R16]
	property p_bank_size;
		5'(BANK_SIZE_LOG2 - `SC_BANK_SIZE_FIELD_BIAS) == {1'b0, s_r.cfg[`SC_BANK_SIZE_FIELD_HI:`SC_BANK_SIZE_FIELD_LO]};
	endproperty
	a_bank_size: assert property (p_bank_size) else $error("bank size decode wrong"); // [R17]
	property p_io_pri;
		external_bus_priority == `SC_EXTERNAL_BUS_PRIORITY_IOP && BUS_REQ.io_req |-> BUS_GNT.io && !BUS_GNT.dm && !BUS_GNT.pm;
	endproperty
	a_io_pri: assert property (p_io_pri) else $error("core won under io priority"); // [R20]
	property p_pm_next;
		core_win && !BUS_REQ.dm_req && BUS_REQ.pm_req |-> BUS_GNT.pm && !BUS_GNT.io;
	endproperty
	a_pm_next: assert property (p_pm_next) else $error("pm slot not given"); // [R19]
	property p_bso_off;
		!s_r.cfg[`SC_B_BSO] && !SOFT_RESET |=> BANK_SEL_N == ~$past(BANK_REQ);
	endproperty
	a_bso_off: assert property (p_bso_off) else $error("bank selects not passed"); // [R2]
	property p_ivt_int;
		!booting && s_r.cfg[`SC_B_VECTOR_TABLE_INTERNAL_BIT] |-> VECTOR_BASE == `SC_IVT_INT;
	endproperty
	a_ivt_int: assert property (p_ivt_int) else $error("vector table not internal"); // [R3]

	c_flush: cover property (PACK_FLUSH);
	c_soft_reset_bit: cover property (SOFT_RESET);
	c_even: cover property (BUS_GNT.io ##1 BUS_GNT.dm ##1 BUS_GNT.io);
	c_bso: cover property (s_r.cfg[`SC_B_BSO] && !BOOT_SEL_N);
endmodule

// file: verilog/syscfg_cfg.svh
// system configuration block: addresses, field positions, reset and codes
// assumes inclusion by bare name from the top module, the dma arbiter and the bench
`ifndef SYSCFG_CFG_SVH
`define SYSCFG_CFG_SVH
`define SC_ADDR 32'h0000_0000
`define SC_RESET 32'h0000_0010
`define SC_WMASK 32'h0007_FF7E
`define SC_B_SOFT_RESET_BIT 0
`define SC_B_BSO 1
`define SC_B_VECTOR_TABLE_INTERNAL_BIT 2
`define SC_B_IWT 3
`define SC_HPM_LO 4
`define SC_HPM_HI 5
`define SC_B_HOST_PACK_HIGH_FIRST 6
`define SC_B_FLUSH 7
`define SC_B_BLK0 8
`define SC_B_BLK1 9
`define SC_B_REDY 10
`define SC_B_BHD 11
`define SC_BANK_SIZE_FIELD_LO 12
`define SC_BANK_SIZE_FIELD_HI 15
`define SC_EXTERNAL_BUS_PRIORITY_LO 16
`define SC_EXTERNAL_BUS_PRIORITY_HI 17
`define SC_B_DMA_CHANNEL_PRIORITY_BIT 18
`define SC_BANK_SIZE_FIELD_BIAS 5'h0D
`define SC_IVT_INT 32'h0002_0000
`define SC_IVT_EXT 32'h0040_0000
`define SC_HPM_NONE 2'h0
`define SC_HPM_16_32 2'h1
`define SC_HPM_16_48 2'h2
`define SC_HPM_32_48 2'h3
`define SC_EXTERNAL_BUS_PRIORITY_EVEN 2'h0
`define SC_EXTERNAL_BUS_PRIORITY_CORE 2'h1
`define SC_EXTERNAL_BUS_PRIORITY_IOP 2'h2
`define SC_LOW16_MASK 48'hFFFF_FFFF_0000
`define SC_BANK_OFF 4'hF
`define SC_DMA_FIRST 4'h1
`endif

// file: verilog/syscfg_pkg.sv
// types shared by the system configuration block and its dma arbiter
// assumes the cfg header is on the include path
package syscfg_pkg;
	// gray along idle, wait, fire
	typedef enum logic [1:0] {
		SC_FL_IDLE = 2'h0,
		SC_FL_WAIT = 2'h1,
		SC_FL_FIRE = 2'h3
	} syscfg_flush_t;
	typedef enum logic [1:0] {SC_W32 = 2'h0, SC_W40 = 2'h1, SC_W48 = 2'h2} syscfg_width_t;
	typedef enum logic [1:0] {
		SC_TGT_MEM = 2'h0,
		SC_TGT_IOP = 2'h1,
		SC_TGT_LINK = 2'h2,
		SC_TGT_PORT = 2'h3
	} syscfg_target_t;
	typedef struct packed {
		logic pm_req;
		logic dm_req;
		logic pm_write;
		logic dm_write;
		logic io_req;
	} syscfg_bus_req_t;
	typedef struct packed {
		logic pm;
		logic dm;
		logic io;
	} syscfg_bus_gnt_t;
	typedef struct packed {
		logic [31:0] cfg;
		syscfg_flush_t flush;
		logic soft_reset_bit;
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic last_io;
		logic [3:0] bank_n;
		logic boot_n;
		logic [47:0] data;
		logic [31:0] rdata;
	} syscfg_state_t;
	typedef struct packed {
		logic [1:0] head;
	} syscfg_arb_state_t;
endpackage

// file: verilog/syscfg_dma_arb.sv
// priority arbiter for the four external port dma channels (6 to 9)
// assumes requests from logic on the same clock; clr is a one-cycle soft reset
`timescale 1ns/1ps
`include "syscfg_cfg.svh"
module syscfg_dma_arb
	import syscfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic rotate,
	input wire logic [3:0] req,
	output logic [3:0] gnt
);
	syscfg_arb_state_t s_r;
	syscfg_arb_state_t n;

	// first requester walking up from head, wrapping modulo four
	function automatic logic [3:0] pick(input logic [3:0] r, input logic [1:0] head);
		logic [3:0] g;
		logic [1:0] ch;
		g = 4'h0;
		for (int i = 0; i < 4; i++) begin
			ch = head + i[1:0];
			if (g == 4'h0 && r[ch]) g[ch] = 1'b1;
		end
		return g;
	endfunction

	// grant and head update; fixed mode searches from channel 6 and leaves head unchanged
	always_comb begin
		n = s_r;
		gnt = pick(req, rotate ? s_r.head : 2'h0); // [R22]
		for (int i = 0; i < 4; i++) begin
			if (rotate && gnt[i]) n.head = 2'(i + 1); // [R22]
		end
		if (clr) n.head = 2'h0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) s_r <= '{head: 2'h0};
		else s_r <= n;
	end

	property p_fixed_first;
		@(posedge clk) disable iff (rst) !rotate && req[0] |-> gnt == `SC_DMA_FIRST;
	endproperty
	a_fixed_first: assert property (p_fixed_first) else $error("ch6 not first"); // [R22]
	property p_rotate_next;
		@(posedge clk) disable iff (rst || clr)
			(rotate && gnt[0]) ##1 (rotate && req == 4'hF) |-> gnt == 4'h2;
	endproperty
	a_rotate_next: assert property (p_rotate_next) else $error("no rotation"); // [R22]
	property p_one_grant;
		@(posedge clk) disable iff (rst) $onehot0(gnt) && ((|req) == (|gnt));
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("bad grant"); // [R22]
	c_rotate_wrap: cover property (@(posedge clk) disable iff (rst)
		rotate && gnt[3] ##1 rotate && gnt[0]);
endmodule

// file: test/syscfg_host_model.sv
// host partner: drives the register port of the configuration block
// assumes one clock shared with the block; the bench calls its tasks
`timescale 1ns/1ps
module syscfg_host_model (
	input wire logic clk,
	output logic [31:0] addr,
	output logic we,
	output logic re,
	output logic [31:0] wdata
);
	// idle values at time zero, port not selected
	initial begin
		addr = 32'hFFFF_FFFF;
		we = 1'b0;
		re = 1'b0;
		wdata = 32'h0;
	end
	// strobe held over one sampling edge; released lines show inverted values
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk) #1;
		addr = a;
		wdata = d;
		we = 1'b1;
		@(posedge clk) #1;
		we = 1'b0;
		addr = ~a;
		wdata = ~d;
	endtask
	task automatic rd(input logic [31:0] a);
		@(posedge clk) #1;
		addr = a;
		re = 1'b1;
		@(posedge clk) #1;
		re = 1'b0;
		addr = ~a;
	endtask
	// second write flushes a read that may have used the old packing
	task automatic pack_change(input logic [31:0] d);
		wr(32'h0, d);
		rd(32'h0);
		wr(32'h0, d);
		repeat (4) @(posedge clk);
		#1;
	endtask
endmodule

// file: test/tb_system_configuration_control.sv
// bench for the system configuration block: register, decodes, arbiters
// assumes the host partner model owns the register port
`timescale 1ns/1ps
`include "syscfg_cfg.svh"
module tb_system_configuration_control
	import syscfg_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, we, re, soft_reset_bit, boot_n, hup, hhf, pflush, b0w, b1w, redy, stall;
	logic eb, lb, bm, boot_req, dblk, hblk;
	logic be, bf, re_d = 1'b0;
	logic [31:0] addr, wdata, rdata, vbase, w;
	logic [3:0] bank_req, dreq, bsel_n, dgnt, g4;
	logic [1:0] host_pack_mode;
	logic [4:0] msz;
	logic [47:0] hdin, hdout;
	syscfg_width_t dwid, hwid;
	syscfg_target_t htgt;
	syscfg_bus_req_t breq;
	syscfg_bus_gnt_t bgnt, g;
	logic [31:0] exp_q[$];
	int bad_count = 0, samples_checked = 0, cyc = 0;
	int seed = 32'h921AF46C;

	syscfg_host_model host (.clk(clk), .addr(addr), .we(we), .re(re), .wdata(wdata));
	syscfg_top dut (
		.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WE(we), .REG_RE(re), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .SOFT_RESET(soft_reset_bit), .EPROM_BOOT_STRAP(eb), .LINK_BOOT_STRAP(lb),
		.BOOT_MEM_STRAP(bm), .VECTOR_BASE(vbase), .BANK_REQ(bank_req), .BOOT_REQ(boot_req),
		.BANK_SEL_N(bsel_n), .BOOT_SEL_N(boot_n), .DIRECT_BLOCK(dblk), .DIRECT_WIDTH(dwid),
		.HOST_TARGET(htgt), .HOST_BLOCK(hblk), .HOST_WIDTH(hwid), .HOST_UPPER32(hup),
		.HOST_PACK_MODE(host_pack_mode), .HOST_PACK_HIGH_FIRST(hhf), .PACK_FLUSH(pflush),
		.HOST_DATA_IN(hdin), .HOST_DATA_OUT(hdout), .BLOCK0_WIDE(b0w), .BLOCK1_WIDE(b1w),
		.REDY_ACTIVE_DRIVE(redy), .BUF_EMPTY_RD(be), .BUF_FULL_WR(bf), .BUF_STALL(stall),
		.BANK_SIZE_LOG2(msz), .BUS_REQ(breq), .BUS_GNT(bgnt), .DMA_REQ(dreq), .DMA_GNT(dgnt)
	);

	// 100 ns period
	always #50 clk = ~clk;

	task automatic chk(input string n, input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// expected read noted before the strobe, popped when the data stands
	task automatic rdx(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		host.rd(a);
	endtask

	// discarded reads of a mode change find the queue empty and are skipped
	always @(posedge clk) re_d <= re;
	always @(negedge clk) begin
		if (re_d && exp_q.size() > 0) begin
			chk("read_data", rdata, exp_q.pop_front());
		end
	end

	// hang guard, generous against the few hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		// every input starts idle; data bus starts on a random word
		{eb, lb, bm, boot_req, dblk, hblk, be, bf} = 8'h00;
		bank_req = 4'h0;
		dreq = 4'h0;
		hdin = {$random(seed), 16'($random(seed))};
		htgt = SC_TGT_MEM;
		breq = '0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		rdx(32'h0, `SC_RESET);
		chk("pack_mode", host_pack_mode, `SC_HPM_16_32);
		host.wr(32'h4, 32'h0);
		rdx(32'h4, 32'h0);
		rdx(32'h0, `SC_RESET);
		// first pass all ones, then random fields; soft reset and flush kept off
		for (int i = 0; i < 6; i++) begin
			w = (i == 0 ? 32'hFFFF_FFFF : $random(seed)) & 32'hFFFF_FF7E;
			be = w[20];
			bf = w[21];
			host.pack_change(w);
			rdx(32'h0, w & `SC_WMASK);
			chk("pack_mode", host_pack_mode, w[5:4]);
			chk("high_first", hhf, w[6] & (w[5:4] == 2'h1 || w[5:4] == 2'h2));
			chk("blk0_wide", b0w, w[8]);
			chk("blk1_wide", b1w, w[9]);
			chk("redy_drive", redy, w[10]);
			chk("stall", stall, (w[20] | w[21]) & ~w[11]);
			chk("bank_log2", msz, {1'b0, w[15:12]} + 5'h0D);
		end
		host.pack_change(32'h14);
		chk("vector", vbase, `SC_IVT_INT);
		host.pack_change(32'h10);
		chk("vector", vbase, `SC_IVT_EXT);
		for (int k = 0; k < 3; k++) begin
			{eb, lb, bm} = 3'h1 << k;
			repeat (3) @(posedge clk);
			#1;
			chk("vector", vbase, `SC_IVT_INT);
		end
		{eb, lb, bm} = 3'h0;
		// bank selects plain, then turned over to the boot select
		bank_req = 4'h5;
		boot_req = 1'($random(seed));
		@(posedge clk) #1;
		chk("bank_sel", bsel_n, 4'hA);
		chk("boot_sel", boot_n, !boot_req);
		host.pack_change(32'h12);
		chk("bank_sel", bsel_n, 4'hF);
		chk("boot_sel", boot_n, 1'b0);
		bank_req = 4'h0;
		boot_req = 1'b0;
		// access widths
		host.pack_change(32'h218);
		#1 chk("direct_w", dwid, SC_W48);
		host.pack_change(32'h210);
		dblk = 1'b1;
		#1 chk("direct_w", dwid, SC_W40);
		dblk = 1'b0;
		#1 chk("direct_w", dwid, SC_W32);
		htgt = SC_TGT_IOP;
		#1 chk("host_w", hwid, SC_W32);
		htgt = SC_TGT_MEM;
		hblk = 1'b1;
		#1 chk("upper32", hup, 1'b1);
		htgt = SC_TGT_LINK;
		host.pack_change(32'h20);
		chk("host_w", hwid, SC_W48);
		// port buffers: host side kept at the 16/48 width the dma side would use
		htgt = SC_TGT_PORT;
		#1 chk("port_w", hwid, SC_W48);
		host.pack_change(32'h0);
		hdin[47:16] = $random(seed);
		hdin[15:0] = 16'($random(seed));
		@(posedge clk) #1;
		chk("host_data", hdout, hdin & `SC_LOW16_MASK);
		// flush pulse two cycles after the write, bit reads zero
		host.wr(32'h0, 32'h80);
		chk("flush", pflush, 1'b0);
		@(posedge clk) #1;
		chk("flush", pflush, 1'b1);
		@(posedge clk) #1;
		chk("flush", pflush, 1'b0);
		rdx(32'h0, 32'h0);
		// external bus: core, io and even priority
		host.pack_change(32'h1_0010);
		breq = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		#1 chk("bus", bgnt, 3'b010);
		breq = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
		#1 chk("bus", bgnt, 3'b100);
		host.pack_change(32'h2_0010);
		breq = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		#1 chk("bus", bgnt, 3'b001);
		host.pack_change(32'h10);
		breq = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		for (int k = 0; k < 4; k++) begin
			#1 g = bgnt;
			@(posedge clk) #1;
			chk("bus", bgnt, g ^ 3'b011);
		end
		breq = '0;
		// dma: fixed order, then rotating
		dreq = 4'hC;
		#1 chk("dma", dgnt, 4'h4);
		host.pack_change(32'h4_0010);
		dreq = 4'hF;
		for (int k = 0; k < 5; k++) begin
			#1 g4 = dgnt;
			@(posedge clk) #1;
			chk("dma", dgnt, {g4[2:0], g4[3]});
		end
		dreq = 4'h0;
		host.wr(32'h0, 32'h3);
		chk("soft_rst", soft_reset_bit, 1'b1);
		@(posedge clk) #1;
		chk("soft_rst", soft_reset_bit, 1'b0);
		rdx(32'h0, `SC_RESET);
		final_report();
	end
endmodule
